// *** logic/rtcc_top.sv ***
// RTC interval alarm, timekeeping, 128 Hz register update and calibration pulse output.
// Assumes a core that issues one-cycle SFR read and write strobes at 40 MHz.
//
// Behaviour
// - Interval enable feeds the selected time base into an 8-bit counter.
// - Counter increments per pulse; equality with interval sets alarm and pending interrupt.
// - Single-shot clear: counter clears after alarm and counting resumes.
// - Single-shot set: counter held in reset after the alarm.
// - New time base takes effect within one 128 Hz period.
// - Alarm requests core wake-up when it occurs in deepest sleep.
// - Crystal error compensated by inserting or removing pulses, up to 248 ppm.
// - Each nominal compensation LSB is 2 ppm.
// - Temperature plus nominal compensation summed and limited to plus or minus 248 ppm.
// - Calibration pulse drives shared pin only while its enable bit is set.
// - Select 00 gives 1 Hz, 01 gives 512 Hz, normal window.
// - Select 10 gives 500 Hz, 11 gives 16 kHz, active modes only.
// - Fast calibration modes clock timekeeping 125 times faster.
// - Configuration and interval writes reach the RTC within two 128 Hz periods.
// - Pending interrupt stays until taken; alarm flag stays until software clears it.
// - Timekeeping runs on the 32.768 kHz stream; configuration on 128 Hz.
`timescale 1ns/10ps
`include "rtcc_defines.svh"
module rtcc_top (
	input  wire logic       clock,                      // Core clock, 40 MHz.
	input  wire logic       reset_n,                    // Asynchronous reset, active low.
	input  wire logic [7:0] sfr_addr,                   // SFR address.
	input  wire logic       sfr_write,                  // One-cycle write strobe.
	input  wire logic       sfr_read,                   // One-cycle read strobe.
	input  wire logic [7:0] sfr_wdata,                  // Write data.
	output logic      [7:0] sfr_rdata,                  // Read data, valid the cycle after the strobe.
	input  wire logic [1:0] power_mode,                 // Current power saving mode.
	input  wire logic       irq_taken,                  // Core vectors to the RTC interrupt.
	output logic            rtc_irq_pending,            // RTC interrupt pending.
	output logic            wake_request,               // Wake-up request to the core.
	output logic            shared_calibration_pin_out, // Calibration pulse level.
	output logic            shared_calibration_pin_oe   // High while the pin is driven.
);
	rtcc_pkg::rtcc_state_t s_reg;
	rtcc_pkg::rtcc_state_t s_next;
	rtcc_comp_if comp_link ();

	rtcc_compensate u_compensate (
		.clock   (clock),
		.reset_n (reset_n),
		.link    (comp_link)
	);

	logic       tick;
	logic       fast_mode;
	logic [8:0] pre_sum;
	logic       hund_tick;
	logic       sec_tick;
	logic       min_tick;
	logic       hour_tick;
	logic       update_tick;
	logic       interval_pulse;
	logic [7:0] cnt_inc;
	logic       alarm_event;
	logic       cfg_wr;
	logic       clear_alarm;
	logic       cal_event;

	assign comp_link.nominal = s_reg.nominal;
	assign comp_link.temperature = s_reg.temperature;
	assign tick = comp_link.rtc_tick;

	always_comb begin
		s_next = s_reg;

		// ************************************************************
		// Timekeeping on the compensated crystal stream
		// ************************************************************
		fast_mode = s_reg.pincfg[`RTCC_PIN_CALEN_BIT] && s_reg.pincfg[`RTCC_PIN_CALIBRATION_FREQUENCY_SELECT_HI]
			&& (power_mode != rtcc_pkg::RTCC_SLEEP_POWER);
		// A fast step of 125 stays under 256, so one tick never crosses two hundredths.
		pre_sum = {1'b0, s_reg.prescale} + (fast_mode ? `RTCC_FAST_STEP : `RTCC_NORMAL_STEP);
		hund_tick = tick && pre_sum[8];
		sec_tick = hund_tick && (s_reg.hundredths == `RTCC_HUND_LAST);
		min_tick = sec_tick && (s_reg.seconds == `RTCC_SEC_LAST);
		hour_tick = min_tick && (s_reg.minutes == `RTCC_MIN_LAST);
		if (tick) begin
			s_next.prescale = pre_sum[7:0];
		end
		if (hund_tick) begin
			s_next.hundredths = s_reg.hundredths + 7'h01;
		end
		if (sec_tick) begin
			s_next.seconds = (s_reg.seconds == `RTCC_SEC_LAST) ? 6'h00 : s_reg.seconds + 6'h01;
		end
		if (min_tick) begin
			s_next.minutes = (s_reg.minutes == `RTCC_MIN_LAST) ? 6'h00 : s_reg.minutes + 6'h01;
		end
		if (hour_tick) begin
			s_next.hours = (s_reg.hours == `RTCC_HOUR_LAST) ? 5'h00 : s_reg.hours + 5'h01;
		end

		// ************************************************************
		// 128 Hz update of configuration and interval
		// ************************************************************
		// The update divider counts raw ticks so fast calibration leaves the register update rate alone.
		update_tick = tick && (s_reg.update_div == `RTCC_UPDATE_DIV);
		if (tick) begin
			s_next.update_div = s_reg.update_div + 8'h01;
		end
		if (update_tick) begin
			s_next.enable_act = s_reg.cfg_shadow[`RTCC_CFG_ENABLE_BIT];
			s_next.single_act = s_reg.cfg_shadow[`RTCC_CFG_SINGLE_BIT];
			s_next.tbase_act = s_reg.cfg_shadow[`RTCC_CFG_TBASE_HI:`RTCC_CFG_TBASE_LO];
			s_next.interval_act = s_reg.interval_shadow;
		end

		// ************************************************************
		// Interval timer
		// ************************************************************
		unique case (s_reg.tbase_act)
			2'b00: interval_pulse = hund_tick;
			2'b01: interval_pulse = sec_tick;
			2'b10: interval_pulse = min_tick;
			2'b11: interval_pulse = hour_tick;
		endcase
		cnt_inc = s_reg.interval_cnt + 8'h01;
		alarm_event = 1'b0;
		if (!s_reg.enable_act) begin
			s_next.interval_cnt = 8'h00;
			s_next.single_held = 1'b0;
		end else if (s_reg.single_held) begin
			s_next.interval_cnt = 8'h00;
		end else if (interval_pulse) begin
			if (cnt_inc == s_reg.interval_act) begin
				alarm_event = 1'b1;
				s_next.interval_cnt = 8'h00;
				s_next.single_held = s_reg.single_act;
			end else begin
				s_next.interval_cnt = cnt_inc;
			end
		end

		// ************************************************************
		// Register writes
		// ************************************************************
		cfg_wr = sfr_write && (sfr_addr == `RTCC_ADDR_CONFIG);
		clear_alarm = cfg_wr && !sfr_wdata[`RTCC_CFG_ALARM_BIT];
		if (cfg_wr) begin
			s_next.cfg_shadow = sfr_wdata;
		end
		if (sfr_write && (sfr_addr == `RTCC_ADDR_INTERVAL)) begin
			s_next.interval_shadow = sfr_wdata;
		end
		if (sfr_write && (sfr_addr == `RTCC_ADDR_NOMINAL)) begin
			s_next.nominal = sfr_wdata;
		end
		if (sfr_write && (sfr_addr == `RTCC_ADDR_TEMP)) begin
			s_next.temperature = sfr_wdata;
		end
		if (sfr_write && (sfr_addr == `RTCC_ADDR_PINCFG)) begin
			s_next.pincfg = sfr_wdata;
		end

		// ************************************************************
		// Flags, interrupt and wake-up
		// ************************************************************
		// Writing zero to the alarm bit clears it; a same-cycle alarm still wins.
		if (alarm_event) begin
			s_next.alarm_flag = 1'b1;
		end else if (clear_alarm) begin
			s_next.alarm_flag = 1'b0;
		end
		if (alarm_event) begin
			s_next.irq_pending = 1'b1;
		end else if (irq_taken) begin
			s_next.irq_pending = 1'b0;
		end
		// The wake request holds until the interrupt is taken, so the core keeps waking until served.
		if (alarm_event && (power_mode == rtcc_pkg::RTCC_SLEEP_POWER)) begin
			s_next.wake_request = 1'b1;
		end else if (irq_taken) begin
			s_next.wake_request = 1'b0;
		end

		// ************************************************************
		// Calibration pulse output
		// ************************************************************
		if (tick) begin
			s_next.div512 = s_reg.div512 + 6'h01;
		end
		if (hund_tick) begin
			s_next.div500 = s_reg.div500 + 5'h01;
		end
		if (fast_mode) begin
			if (s_reg.pincfg[`RTCC_PIN_CALIBRATION_FREQUENCY_SELECT_LO]) begin
				cal_event = hund_tick;
			end else begin
				cal_event = hund_tick && (s_reg.div500 == `RTCC_500HZ_LAST);
			end
		end else if (s_reg.pincfg[`RTCC_PIN_CALIBRATION_FREQUENCY_SELECT_HI]) begin
			cal_event = 1'b0;
		end else if (s_reg.pincfg[`RTCC_PIN_CALIBRATION_FREQUENCY_SELECT_LO]) begin
			cal_event = tick && (s_reg.div512 == `RTCC_512HZ_LAST);
		end else begin
			cal_event = sec_tick;
		end
		s_next.cal_oe = s_reg.pincfg[`RTCC_PIN_CALEN_BIT];
		s_next.cal_out = s_reg.pincfg[`RTCC_PIN_CALEN_BIT] && cal_event;

		// ************************************************************
		// Register reads
		// ************************************************************
		if (sfr_read) begin
			unique case (sfr_addr)
				`RTCC_ADDR_CONFIG: begin
					s_next.rdata = s_reg.cfg_shadow;
					s_next.rdata[`RTCC_CFG_ENABLE_BIT] = s_reg.enable_act;
					s_next.rdata[`RTCC_CFG_ALARM_BIT] = s_reg.alarm_flag;
				end
				`RTCC_ADDR_HUNDREDTHS: s_next.rdata = {1'b0, s_reg.hundredths};
				`RTCC_ADDR_SECONDS:    s_next.rdata = {2'b00, s_reg.seconds};
				`RTCC_ADDR_MINUTES:    s_next.rdata = {2'b00, s_reg.minutes};
				`RTCC_ADDR_HOURS:      s_next.rdata = {3'b000, s_reg.hours};
				`RTCC_ADDR_INTERVAL:   s_next.rdata = s_reg.interval_shadow;
				`RTCC_ADDR_NOMINAL:    s_next.rdata = s_reg.nominal;
				`RTCC_ADDR_TEMP:       s_next.rdata = s_reg.temperature;
				`RTCC_ADDR_PINCFG:     s_next.rdata = s_reg.pincfg;
				default:               s_next.rdata = `RTCC_RESET_BYTE;
			endcase
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign sfr_rdata = s_reg.rdata;
	assign rtc_irq_pending = s_reg.irq_pending;
	assign wake_request = s_reg.wake_request;
	assign shared_calibration_pin_out = s_reg.cal_out;
	assign shared_calibration_pin_oe = s_reg.cal_oe;
endmodule

// *** inc/rtcc_defines.svh ***
// Register offsets, field positions, reset values and timing counts of the RTC interval alarm and calibration block.
// Assumes a core that reaches special function registers at 8-bit addresses.
`ifndef RTCC_DEFINES_SVH
`define RTCC_DEFINES_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define RTCC_ADDR_CONFIG     8'ha1
`define RTCC_ADDR_HUNDREDTHS 8'ha2
`define RTCC_ADDR_SECONDS    8'ha3
`define RTCC_ADDR_MINUTES    8'ha4
`define RTCC_ADDR_HOURS      8'ha5
`define RTCC_ADDR_INTERVAL   8'ha6
`define RTCC_ADDR_NOMINAL    8'hf6
`define RTCC_ADDR_TEMP       8'hf7
`define RTCC_ADDR_PINCFG     8'hff

// ************************************************************
// Field positions
// ************************************************************
`define RTCC_CFG_ENABLE_BIT   1
`define RTCC_CFG_ALARM_BIT    2
`define RTCC_CFG_SINGLE_BIT   3
`define RTCC_CFG_TBASE_LO     4
`define RTCC_CFG_TBASE_HI     5
`define RTCC_PIN_CALEN_BIT    7
`define RTCC_PIN_CALIBRATION_FREQUENCY_SELECT_HI      6
`define RTCC_PIN_CALIBRATION_FREQUENCY_SELECT_LO      5

// ************************************************************
// Reset values
// ************************************************************
`define RTCC_RESET_BYTE 8'h00

// ************************************************************
// Timing
// ************************************************************
`define RTCC_CORE_HZ        40000000
`define RTCC_XTAL_HZ        32768
`define RTCC_PHASE_STEP     32'd3518437
`define RTCC_UPDATE_DIV     8'hff
`define RTCC_FAST_STEP      9'h07d
`define RTCC_NORMAL_STEP    9'h001
`define RTCC_PPM_PER_LSB    20'd2
`define RTCC_PPM_WINDOW     20'd1000000
`define RTCC_COMP_LIMIT     9'sd124
`define RTCC_HUND_LAST      7'h7f
`define RTCC_SEC_LAST       6'h3b
`define RTCC_MIN_LAST       6'h3b
`define RTCC_HOUR_LAST      5'h17
`define RTCC_512HZ_LAST     6'h3f
`define RTCC_500HZ_LAST     5'h1f

`endif

// *** inc/rtcc_pkg.sv ***
// Types shared by the RTC interval alarm and calibration modules.
// Assumes rtcc_defines.svh is compiled alongside.
package rtcc_pkg;

	typedef enum logic [1:0] {
		RTCC_FULL_POWER,
		RTCC_BATTERY_POWER,
		RTCC_SLEEP_POWER
	} rtcc_power_mode_t;

	typedef struct packed {
		logic [31:0] phase;
		logic [19:0] ppm_acc;
		logic        insert_due;
		logic        rtc_tick;
	} rtcc_comp_state_t;

	typedef struct packed {
		logic [7:0] cfg_shadow;
		logic [7:0] interval_shadow;
		logic [7:0] nominal;
		logic [7:0] temperature;
		logic [7:0] pincfg;
		logic       enable_act;
		logic       single_act;
		logic [1:0] tbase_act;
		logic [7:0] interval_act;
		logic [7:0] update_div;
		logic [7:0] prescale;
		logic [6:0] hundredths;
		logic [5:0] seconds;
		logic [5:0] minutes;
		logic [4:0] hours;
		logic [7:0] interval_cnt;
		logic       single_held;
		logic       alarm_flag;
		logic       irq_pending;
		logic       wake_request;
		logic [5:0] div512;
		logic [4:0] div500;
		logic       cal_out;
		logic       cal_oe;
		logic [7:0] rdata;
	} rtcc_state_t;

endpackage

// *** inc/rtcc_comp_if.sv ***
// Carrier between the RTC core and its crystal compensation unit.
// Assumes both ends share the single core clock.
`timescale 1ns/10ps
interface rtcc_comp_if;
	logic [7:0] nominal;
	logic [7:0] temperature;
	logic       rtc_tick;

	modport core (output nominal, output temperature, input rtc_tick);
	modport comp (input nominal, input temperature, output rtc_tick);
endinterface

// *** logic/rtcc_compensate.sv ***
// Crystal time base and digital pulse compensation for the RTC.
// Assumes a 40 MHz core clock; the 32.768 kHz stream is made from it by a phase accumulator.
`timescale 1ns/10ps
`include "rtcc_defines.svh"
module rtcc_compensate (
	input  wire logic clock,     // Core clock.
	input  wire logic reset_n,   // Asynchronous reset, active low.
	rtcc_comp_if.comp link       // Compensation values in, compensated tick out.
);
	rtcc_pkg::rtcc_comp_state_t s_reg;
	rtcc_pkg::rtcc_comp_state_t s_next;

	logic signed [8:0] sum;
	logic signed [8:0] applied;
	logic        [8:0] magnitude;
	logic        [32:0] phase_sum;
	logic        [19:0] ppm_sum;

	always_comb begin
		s_next = s_reg;
		sum = 9'(signed'(link.nominal)) + 9'(signed'(link.temperature));
		if (sum > `RTCC_COMP_LIMIT) begin
			applied = `RTCC_COMP_LIMIT;
		end else if (sum < -`RTCC_COMP_LIMIT) begin
			applied = -`RTCC_COMP_LIMIT;
		end else begin
			applied = sum;
		end
		magnitude = applied[8] ? 9'(-applied) : 9'(applied);
		phase_sum = {1'b0, s_reg.phase} + {1'b0, `RTCC_PHASE_STEP};
		ppm_sum = s_reg.ppm_acc + 20'(magnitude) * `RTCC_PPM_PER_LSB;
		s_next.phase = phase_sum[31:0];
		s_next.rtc_tick = 1'b0;
		// An inserted pulse goes out in the cycle after the crystal pulse, well before the next one.
		if (s_reg.insert_due) begin
			s_next.rtc_tick = 1'b1;
			s_next.insert_due = 1'b0;
		end
		if (phase_sum[32]) begin
			s_next.rtc_tick = 1'b1;
			if (ppm_sum >= `RTCC_PPM_WINDOW) begin
				s_next.ppm_acc = ppm_sum - `RTCC_PPM_WINDOW;
				if (applied[8]) begin
					s_next.rtc_tick = 1'b0;
				end else begin
					s_next.insert_due = 1'b1;
				end
			end else begin
				s_next.ppm_acc = ppm_sum;
			end
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign link.rtc_tick = s_reg.rtc_tick;
endmodule

// *** verification/rtcc_top_asserts.sv ***
// Concurrent checks on the ports of the RTC interval alarm and calibration top level.
// Assumes it is bound to rtcc_top and sees only that module's ports.
`timescale 1ns/10ps
module rtcc_top_asserts (
	input wire logic       clock,                      // Core clock.
	input wire logic       reset_n,                    // Reset, active low.
	input wire logic [7:0] sfr_addr,                   // SFR address.
	input wire logic       sfr_write,                  // Write strobe.
	input wire logic       sfr_read,                   // Read strobe.
	input wire logic [7:0] sfr_wdata,                  // Write data.
	input wire logic [7:0] sfr_rdata,                  // Read data.
	input wire logic [1:0] power_mode,                 // Power mode.
	input wire logic       irq_taken,                  // Interrupt taken.
	input wire logic       rtc_irq_pending,            // Interrupt pending.
	input wire logic       wake_request,               // Wake-up request.
	input wire logic       shared_calibration_pin_out, // Calibration pulse.
	input wire logic       shared_calibration_pin_oe   // Pin drive enable.
);
	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	logic mapped;
	logic hit_pin;
	assign mapped = (sfr_addr >= 8'ha1 && sfr_addr <= 8'ha6) || sfr_addr == 8'hf6 || sfr_addr == 8'hf7 ||
		sfr_addr == 8'hff;
	assign hit_pin = sfr_write && sfr_addr == 8'hff;

	a_unmapped_read: assert property (sfr_read && !mapped |=> sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_rdata_hold: assert property (!sfr_read |=> $stable(sfr_rdata))
		else $error("read data moved without a read");
	a_interval_echo: assert property ((sfr_write && sfr_addr == 8'ha6 ##2 sfr_read && sfr_addr == 8'ha6) |=>
		sfr_rdata == $past(sfr_wdata, 3)) else $error("interval readback wrong");
	a_pin_quiet: assert property (!shared_calibration_pin_oe |-> !shared_calibration_pin_out)
		else $error("pulse while pin not driven");
	a_oe_cause: assert property ($changed(shared_calibration_pin_oe) |-> $past(hit_pin) || $past(hit_pin, 2))
		else $error("pin enable moved without a write");
	a_oe_level: assert property (hit_pin ##1 !hit_pin |=> shared_calibration_pin_oe == $past(sfr_wdata[7], 2))
		else $error("pin enable does not follow its bit");
	a_wake_cause: assert property ($rose(wake_request) |-> $past(power_mode) == 2'h2 ||
		$past(power_mode, 2) == 2'h2) else $error("wake request outside sleep");
	a_wake_clear: assert property (irq_taken && power_mode != 2'h2 |=> !wake_request)
		else $error("wake request not cleared");
	a_pend_hold: assert property (rtc_irq_pending && !irq_taken |=> rtc_irq_pending)
		else $error("pending interrupt lost");
	a_secs_range: assert property (sfr_read && sfr_addr == 8'ha3 |=> sfr_rdata < 8'h3c)
		else $error("seconds out of range");
	a_hours_range: assert property (sfr_read && sfr_addr == 8'ha5 |=> sfr_rdata < 8'h18)
		else $error("hours out of range");

	c_alarm: cover property ($rose(rtc_irq_pending));
	c_pulse: cover property (shared_calibration_pin_out);
	c_unmapped: cover property (sfr_read && !mapped);
endmodule

bind rtcc_top rtcc_top_asserts chk_u (.clock(clock), .reset_n(reset_n), .sfr_addr(sfr_addr),
	.sfr_write(sfr_write), .sfr_read(sfr_read), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
	.power_mode(power_mode), .irq_taken(irq_taken), .rtc_irq_pending(rtc_irq_pending),
	.wake_request(wake_request), .shared_calibration_pin_out(shared_calibration_pin_out),
	.shared_calibration_pin_oe(shared_calibration_pin_oe));

// *** verification/rtcc_top_tb.sv ***
// Self-checking bench for the RTC interval alarm and calibration top level.
// Assumes the 40 MHz core clock; the design has no way to shorten its 128 Hz update period.
`timescale 1ns/10ps
module rtcc_top_tb;
	logic       clock;
	logic       reset_n;
	logic [7:0] sfr_addr;
	logic       sfr_write;
	logic       sfr_read;
	logic [7:0] sfr_wdata;
	logic [7:0] sfr_rdata;
	logic [1:0] power_mode;
	logic       irq_taken;
	logic       rtc_irq_pending;
	logic       wake_request;
	logic       shared_calibration_pin_out;
	logic       shared_calibration_pin_oe;
	int         num_errors = 0;
	int         cmp_count = 0;
	int         wake_seen = 0;
	logic [7:0] map_addr[9] = '{8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'ha5, 8'ha6, 8'hf6, 8'hf7, 8'hff};
	logic [7:0] rw_addr[3] = '{8'ha6, 8'hf6, 8'hf7};
	logic [7:0] pin_cases[6] = '{8'h60, 8'h80, 8'ha0, 8'hc0, 8'he0, 8'he0};

	rtcc_top dut_u (.clock(clock), .reset_n(reset_n), .sfr_addr(sfr_addr), .sfr_write(sfr_write),
		.sfr_read(sfr_read), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .power_mode(power_mode),
		.irq_taken(irq_taken), .rtc_irq_pending(rtc_irq_pending), .wake_request(wake_request),
		.shared_calibration_pin_out(shared_calibration_pin_out),
		.shared_calibration_pin_oe(shared_calibration_pin_oe));

	// ************************************************************
	// Helpers
	// ************************************************************
	initial clock = 1'b0;
	always #12.5 clock = ~clock;

	function automatic real cal_hz(logic [7:0] pc, logic [1:0] pm);
		if (!pc[7] || (pc[6] && pm == 2'h2)) return 0.0;
		case (pc[6:5])
			2'h0: return 1.0;
			2'h1: return 512.0;
			2'h2: return 500.0;
			default: return 16000.0;
		endcase
	endfunction

	function automatic real hund_hz(logic [7:0] pc, logic [1:0] pm);
		return (pc[7] && pc[6] && pm != 2'h2) ? 16000.0 : 128.0;
	endfunction

	task end_of_test;
		$display("errors %0d, comparisons %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Counts drift with phase, so a window of about five percent plus one event is allowed.
	task chk_rate(input string name, input real exp, input int got);
		cmp_count++;
		if (got < exp - exp / 20.0 - 0.9 || got > exp + exp / 20.0 + 0.9) begin
			num_errors++;
			$display("[FAIL] %s expected %0.2f seen %0d", name, exp, got);
		end
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		#2;
		sfr_addr = a;
		sfr_wdata = d;
		sfr_write = 1'b1;
		@(posedge clock);
		#2;
		sfr_write = 1'b0;
	endtask

	task rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock);
		#2;
		sfr_addr = a;
		sfr_read = 1'b1;
		@(posedge clock);
		#2;
		sfr_read = 1'b0;
		d = sfr_rdata;
	endtask

	task count_alarms(input int n, output int c);
		c = 0;
		repeat (n) begin
			@(posedge clock);
			#2;
			if (wake_request !== 1'b0) wake_seen++;
			if (irq_taken === 1'b0 && rtc_irq_pending === 1'b1) begin
				c++;
				irq_taken = 1'b1;
			end else begin
				irq_taken = 1'b0;
			end
		end
		@(posedge clock);
		#2;
		irq_taken = 1'b0;
	endtask

	initial begin
		#30000000;
		num_errors++;
		end_of_test;
	end

	// ************************************************************
	// Sequence
	// ************************************************************
	initial begin
		logic [7:0] d;
		logic [7:0] h0;
		logic [7:0] h1;
		logic [7:0] pc;
		logic [7:0] a;
		logic [1:0] pm;
		int         c;
		reset_n = 1'b0;
		sfr_addr = 8'h00;
		sfr_write = 1'b0;
		sfr_read = 1'b0;
		sfr_wdata = 8'h00;
		power_mode = 2'h0;
		irq_taken = 1'b0;
		void'($urandom(34396));
		repeat (3) @(posedge clock);
		#2;
		reset_n = 1'b1;
		foreach (map_addr[i]) begin
			rd(map_addr[i], d);
			chk_byte("reset value", 8'h00, d);
		end
		repeat (8) begin
			a = rw_addr[$urandom_range(2, 0)];
			pc = 8'($urandom);
			wr(a, pc);
			rd(a, d);
			chk_byte("register echo", pc, d);
			rd(8'h10 + 8'($urandom_range(15, 0)), d);
			chk_byte("unmapped read", 8'h00, d);
		end
		wr(8'ha6, 8'h03);
		wr(8'ha1, 8'h02);
		for (int i = 0; i < 6; i++) begin
			pc = pin_cases[i];
			pm = (i == 5) ? 2'h2 : 2'($urandom_range(1, 0));
			wr(8'hff, pc);
			power_mode = pm;
			rd(8'ha2, h0);
			c = 0;
			repeat (50000) begin
				@(posedge clock);
				#2;
				if (shared_calibration_pin_out === 1'b1) c++;
			end
			rd(8'ha2, h1);
			chk_byte("pin enable", {7'h0, pc[7]}, {7'h0, shared_calibration_pin_oe});
			chk_rate("calibration pulses", cal_hz(pc, pm) * 50000 * 25.0e-9, c);
			chk_rate("hundredths advance", hund_hz(pc, pm) * 50000 * 25.0e-9, int'((h1 - h0) & 8'h7f));
		end
		power_mode = 2'h0;
		c = 0;
		d = 8'h00;
		while (d[1] !== 1'b1 && c < 400) begin
			repeat (1000) @(posedge clock);
			rd(8'ha1, d);
			c++;
		end
		chk_byte("enable active", 8'h02, d & 8'h02);
		count_alarms(8, c);
		count_alarms(20000, c);
		chk_rate("periodic alarms", 20000 * 25.0e-9 * 16000.0 / 3.0, c);
		// Alarms in full power must never raise the wake request, so any sighting counts.
		chk_rate("wake outside sleep", 0.0, wake_seen);
		rd(8'ha1, d);
		chk_byte("alarm flag", 8'h04, d & 8'h04);
		wr(8'ha1, 8'h0a);
		repeat (320000) @(posedge clock);
		count_alarms(8, c);
		count_alarms(20000, c);
		chk_rate("single shot alarms", 0.0, c);
		end_of_test;
	end
endmodule
